// ### logic/dac_power_status_pkg.sv
package dac_power_status_pkg;

  // Register page that holds this group
  localparam logic [7:0] REG_PAGE = 8'h00;

  // Register offsets
  localparam logic [7:0] CHANNEL_ENABLE_REG_OFFSET = 8'h76;
  localparam logic [7:0] POWER_CONFIG_OFFSET = 8'h78;
  localparam logic [7:0] CHANNEL_POWER_STATUS_OFFSET = 8'h79;
  localparam logic [7:0] DEVICE_MODE_STATUS_OFFSET = 8'h7a;
  localparam logic [7:0] TRANSACTION_CHECKSUM_OFFSET = 8'h7e;

  // Reset values
  localparam logic [7:0] CHANNEL_ENABLE_REG_RESET = 8'hcc;
  localparam logic [7:0] POWER_CONFIG_RESET = 8'h00;
  localparam logic [7:0] CHANNEL_POWER_STATUS_RESET = 8'h00;
  localparam logic [7:0] DEVICE_MODE_STATUS_RESET = 8'h80;
  localparam logic [7:0] TRANSACTION_CHECKSUM_RESET = 8'h00;

  // Field positions
  localparam int DAC_GLOBAL_POWER_ON_BIT = 6;
  localparam int ULTRASOUND_DETECT_ENABLE_BIT = 1;
  localparam int PLL_RUNNING_FLAG_BIT = 4;
  localparam int DEVICE_MODE_FIELD_LSB = 5;
  localparam int CHANNEL_COUNT = 4;

  // Writable bits of the power configuration register (bits 4 and 0 are read-only)
  localparam logic [7:0] POWER_CONFIG_WRITE_MASK = 8'hee;
  // Writable bits of the channel enable register
  localparam logic [7:0] CHANNEL_ENABLE_WRITE_MASK = 8'hff;

  // Device mode codes
  localparam logic [2:0] MODE_SLEEP = 3'h4;
  localparam logic [2:0] MODE_ACTIVE_IDLE = 3'h6;
  localparam logic [2:0] MODE_ACTIVE_RUNNING = 3'h7;

  // One access from the control-port decoder
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ctrl_req_type;

endpackage

// ### logic/dac_power_status_regs.sv
`timescale 1ns/1ps
// What this block does
// - Global power bit low powers down all channels; high powers enabled ones.
// - Power config bit 1 enables ultrasound activity detection, reset zero.
// - Channel power status bits 3..0 show channels 1..4 powered, read-only.
// - Mode field reads 4 sleep, 6 active idle, 7 active with channel on.
// - Mode status bit 4 shows PLL enabled, read-only.
// - Checksum updated by every write to other registers on every page.
// - Writing the checksum register presets it with the written byte.
// - Channel enable bits 3..0 at 0x76 enable channels 1..4.
module dac_power_status_regs (
  input wire logic ref_clk, // 200 MHz control clock
  input wire logic reset_n, // Async reset, active low
  input wire dac_power_status_pkg::ctrl_req_type req, // Decoded control-port access
  input wire logic pll_enabled, // PLL enable level
  input wire logic sleep_mode, // Sleep or software shutdown
  input wire logic record_active, // Any record channel on
  output logic [7:0] rd_data_q, // Read data, valid cycle after read
  output logic [3:0] chan_powered_q, // Channel 1..4 power, bit 3 is ch1
  output logic ultrasound_detect_enable_q // Detection algorithm enable
);

  logic [7:0] power_config_q;
  logic [7:0] power_config_d;
  logic [7:0] channel_enable_reg_q;
  logic [7:0] channel_enable_reg_d;
  logic [3:0] chan_powered_d;
  logic [2:0] device_mode_field_q;
  logic [2:0] device_mode_field_d;
  logic pll_running_flag_q;
  logic [7:0] rd_data_d;
  logic [7:0] write_checksum_value;
  logic cksum_load;
  logic cksum_accumulate;

  // Page and offset match, used for every register
  function automatic logic hits(input dac_power_status_pkg::ctrl_req_type r, input logic [7:0] offset);
    hits = (r.page == dac_power_status_pkg::REG_PAGE) && (r.addr == offset);
  endfunction

  // Writable configuration; read-only bits keep their stored value
  always_comb begin
    power_config_d = power_config_q;
    channel_enable_reg_d = channel_enable_reg_q;
    if (req.write && hits(req, dac_power_status_pkg::POWER_CONFIG_OFFSET)) begin
      power_config_d = (req.wdata & dac_power_status_pkg::POWER_CONFIG_WRITE_MASK)
                     | (power_config_q & ~dac_power_status_pkg::POWER_CONFIG_WRITE_MASK);
    end
    if (req.write && hits(req, dac_power_status_pkg::CHANNEL_ENABLE_REG_OFFSET)) begin
      channel_enable_reg_d = req.wdata & dac_power_status_pkg::CHANNEL_ENABLE_WRITE_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_config_q <= dac_power_status_pkg::POWER_CONFIG_RESET;
      channel_enable_reg_q <= dac_power_status_pkg::CHANNEL_ENABLE_REG_RESET;
    end else begin
      power_config_q <= power_config_d;
      channel_enable_reg_q <= channel_enable_reg_d;
    end
  end

  // Channel power one cycle behind the settings; device mode one cycle behind channel power and sleep
  always_comb begin
    chan_powered_d = '0;
    for (int i = 0; i < dac_power_status_pkg::CHANNEL_COUNT; i++) begin
      chan_powered_d[i] = power_config_q[dac_power_status_pkg::DAC_GLOBAL_POWER_ON_BIT]
                        & channel_enable_reg_q[i];
    end
    // Sleep overrides: shutdown reports 4 even if settings still ask for power
    if (sleep_mode) begin
      device_mode_field_d = dac_power_status_pkg::MODE_SLEEP;
    end else if ((|chan_powered_q) || record_active) begin
      device_mode_field_d = dac_power_status_pkg::MODE_ACTIVE_RUNNING;
    end else begin
      device_mode_field_d = dac_power_status_pkg::MODE_ACTIVE_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      chan_powered_q <= dac_power_status_pkg::CHANNEL_POWER_STATUS_RESET[3:0];
      device_mode_field_q <= dac_power_status_pkg::DEVICE_MODE_STATUS_RESET[7:5];
      pll_running_flag_q <= dac_power_status_pkg::DEVICE_MODE_STATUS_RESET[4];
      ultrasound_detect_enable_q <= dac_power_status_pkg::POWER_CONFIG_RESET[1];
    end else begin
      chan_powered_q <= chan_powered_d;
      device_mode_field_q <= device_mode_field_d;
      pll_running_flag_q <= pll_enabled;
      ultrasound_detect_enable_q <= power_config_d[dac_power_status_pkg::ULTRASOUND_DETECT_ENABLE_BIT];
    end
  end

  // Checksum: preset on its own offset, accumulate on any other write
  assign cksum_load = req.write && hits(req, dac_power_status_pkg::TRANSACTION_CHECKSUM_OFFSET);
  assign cksum_accumulate = req.write && !cksum_load;

  write_checksum_unit checksum (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .load(cksum_load),
    .accumulate(cksum_accumulate),
    .data(req.wdata),
    .write_checksum_value_q(write_checksum_value)
  );

  // Read mux, held between reads; unmapped offsets read zero
  always_comb begin
    rd_data_d = rd_data_q;
    if (req.read) begin
      rd_data_d = 8'h00;
      if (hits(req, dac_power_status_pkg::CHANNEL_ENABLE_REG_OFFSET)) begin
        rd_data_d = channel_enable_reg_q;
      end else if (hits(req, dac_power_status_pkg::POWER_CONFIG_OFFSET)) begin
        rd_data_d = power_config_q;
      end else if (hits(req, dac_power_status_pkg::CHANNEL_POWER_STATUS_OFFSET)) begin
        rd_data_d = {4'h0, chan_powered_q};
      end else if (hits(req, dac_power_status_pkg::DEVICE_MODE_STATUS_OFFSET)) begin
        rd_data_d = {device_mode_field_q, pll_running_flag_q, 4'h0};
      end else if (hits(req, dac_power_status_pkg::TRANSACTION_CHECKSUM_OFFSET)) begin
        rd_data_d = write_checksum_value;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  // Checks; offsets and codes come from the package so a remap cannot leave a stale check
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Global power low forces every channel off, whatever the enables say
  global_off_a: assert property (!power_config_q[dac_power_status_pkg::DAC_GLOBAL_POWER_ON_BIT]
    |=> chan_powered_q == 4'h0)
    else $error("channels powered while global power off");

  // Global power high passes the enables straight through, one cycle later
  enabled_on_a: assert property (power_config_q[dac_power_status_pkg::DAC_GLOBAL_POWER_ON_BIT]
    |=> chan_powered_q == $past(channel_enable_reg_q[3:0]))
    else $error("channel power does not follow enables");

  // Detect enable is taken from the next value, so it moves with the register
  detect_follow_a: assert property (req.write && hits(req, dac_power_status_pkg::POWER_CONFIG_OFFSET)
    |=> ultrasound_detect_enable_q == $past(req.wdata[dac_power_status_pkg::ULTRASOUND_DETECT_ENABLE_BIT]))
    else $error("detect enable did not follow write");

  // Status read returns the channel flags as they stood at the read edge
  status_read_a: assert property (req.read && hits(req, dac_power_status_pkg::CHANNEL_POWER_STATUS_OFFSET)
    |=> rd_data_q == {4'h0, $past(chan_powered_q)})
    else $error("channel status read wrong");

  // Sleep wins over any channel or record activity
  mode_sleep_a: assert property (sleep_mode
    |=> device_mode_field_q == dac_power_status_pkg::MODE_SLEEP)
    else $error("mode not sleep");

  // Awake with nothing running reads the idle code
  mode_idle_a: assert property (!sleep_mode && chan_powered_q == 4'h0 && !record_active
    |=> device_mode_field_q == dac_power_status_pkg::MODE_ACTIVE_IDLE)
    else $error("mode not active idle");

  // Awake with any channel or record path on reads the running code
  mode_run_a: assert property (!sleep_mode && (chan_powered_q != 4'h0 || record_active)
    |=> device_mode_field_q == dac_power_status_pkg::MODE_ACTIVE_RUNNING)
    else $error("mode not active running");

  // Mode read returns the field as it stood at the read edge
  mode_read_a: assert property (req.read && hits(req, dac_power_status_pkg::DEVICE_MODE_STATUS_OFFSET)
    |=> rd_data_q[7:5] == $past(device_mode_field_q))
    else $error("mode field read wrong");

  // Flag lags the pin by one cycle and the read by one more
  pll_flag_a: assert property (req.read && hits(req, dac_power_status_pkg::DEVICE_MODE_STATUS_OFFSET) ##1 1'b1
    |-> rd_data_q[dac_power_status_pkg::PLL_RUNNING_FLAG_BIT] == $past(pll_enabled, 2))
    else $error("pll flag read wrong");

  // Every write elsewhere, on any page, folds its byte into the sum
  cksum_sum_a: assert property (req.write && !hits(req, dac_power_status_pkg::TRANSACTION_CHECKSUM_OFFSET)
    |=> write_checksum_value == 8'($past(write_checksum_value) + $past(req.wdata)))
    else $error("checksum not accumulated");

  // Checksum read returns the running value at the read edge
  cksum_read_a: assert property (req.read && hits(req, dac_power_status_pkg::TRANSACTION_CHECKSUM_OFFSET)
    |=> rd_data_q == $past(write_checksum_value))
    else $error("checksum read wrong");

  // A write to the checksum itself presets it instead of adding
  cksum_load_a: assert property (req.write && hits(req, dac_power_status_pkg::TRANSACTION_CHECKSUM_OFFSET)
    |=> write_checksum_value == $past(req.wdata))
    else $error("checksum not preset");

  // Enable register stores the whole written byte
  enable_store_a: assert property (req.write && hits(req, dac_power_status_pkg::CHANNEL_ENABLE_REG_OFFSET)
    |=> channel_enable_reg_q == $past(req.wdata))
    else $error("channel enable not stored");

  // Read-only config bits never leave their reset level, even if a host writes them
  ro_bits_a: assert property (power_config_q[4] == 1'b0 && power_config_q[0] == 1'b0)
    else $error("read-only config bits changed");

  // Other pages hold none of these registers, so reads there return zero
  other_page_a: assert property (req.read && req.page != dac_power_status_pkg::REG_PAGE
    |=> rd_data_q == 8'h00)
    else $error("other page read not zero");

  // Read data stands between reads, so a slow host may pick it up late
  rd_hold_a: assert property (!req.read |=> rd_data_q == $past(rd_data_q))
    else $error("read data changed without a read");

  // Main scenarios the bench must reach
  power_up_c: cover property (power_config_q[dac_power_status_pkg::DAC_GLOBAL_POWER_ON_BIT] && chan_powered_q != 4'h0);
  active_run_c: cover property (device_mode_field_q == dac_power_status_pkg::MODE_ACTIVE_RUNNING);
  cksum_preset_c: cover property (cksum_load ##1 cksum_accumulate);
  wake_idle_c: cover property (device_mode_field_q == dac_power_status_pkg::MODE_SLEEP
    ##1 device_mode_field_q == dac_power_status_pkg::MODE_ACTIVE_IDLE);
  pll_read_c: cover property (req.read && pll_running_flag_q);

endmodule

// ### logic/write_checksum_unit.sv
`timescale 1ns/1ps
// Running modulo-256 sum of written data bytes
module write_checksum_unit (
  input wire logic ref_clk, // 200 MHz control clock
  input wire logic reset_n, // Async reset, active low
  input wire logic load, // Preset with data
  input wire logic accumulate, // Add data into sum
  input wire logic [7:0] data, // Written byte
  output logic [7:0] write_checksum_value_q // Current checksum
);

  logic [7:0] write_checksum_value_d;

  // Load wins over accumulate; the caller never raises both
  always_comb begin
    write_checksum_value_d = write_checksum_value_q;
    if (load) begin
      write_checksum_value_d = data;
    end else if (accumulate) begin
      write_checksum_value_d = 8'(write_checksum_value_q + data);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      write_checksum_value_q <= dac_power_status_pkg::TRANSACTION_CHECKSUM_RESET;
    end else begin
      write_checksum_value_q <= write_checksum_value_d;
    end
  end

endmodule

// ### sim/dac_power_status_regs_tb.sv
`timescale 1ns/1ps
// Random register traffic with hand-picked corners
module dac_power_status_regs_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic pll_enabled = 1'b0;
  logic sleep_mode = 1'b1; // Sleep first, so the mode field keeps its reset code
  logic record_active = 1'b0;
  dac_power_status_pkg::ctrl_req_type req;
  logic [7:0] rd_data_q, cks, en, pwr, sent, q;
  logic [3:0] chan_powered_q;
  logic ultrasound_detect_enable_q;
  int errors = 0;
  int checks = 0;

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  dac_power_status_regs dut (.ref_clk(ref_clk), .reset_n(reset_n), .req(req), .pll_enabled(pll_enabled),
    .sleep_mode(sleep_mode), .record_active(record_active), .rd_data_q(rd_data_q),
    .chan_powered_q(chan_powered_q), .ultrasound_detect_enable_q(ultrasound_detect_enable_q));
  host_model host (.ref_clk(ref_clk), .rd_data_q(rd_data_q), .req(req));

  // Channels are all off unless the global bit is set
  function automatic logic [3:0] exp_pwr(input logic [7:0] p, input logic [7:0] e);
    return p[6] ? e[3:0] : 4'h0;
  endfunction
  function automatic logic [2:0] exp_mode(input logic s, input logic [3:0] c, input logic r);
    if (s) return 3'h4;
    return (c != 4'h0 || r) ? 3'h7 : 3'h6;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // Track the expected sum and stored bytes alongside each write
  task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
    host.wr(pg, a, d, sent);
    cks = (pg == 8'h00 && a == 8'h7e) ? sent : cks + sent;
    if (pg == 8'h00 && a == 8'h78) pwr = sent;
    if (pg == 8'h00 && a == 8'h76) en = sent;
  endtask
  // Fixed wait covers the two-stage status lag
  task automatic settle;
    host.idle();
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic rdchk(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] want);
    host.rd(pg, a, q);
    check(q, want);
  endtask
  task automatic status;
    check({4'h0, chan_powered_q}, {4'h0, exp_pwr(pwr, en)});
    check({7'h0, ultrasound_detect_enable_q}, {7'h0, pwr[1]});
    rdchk(8'h00, 8'h79, {4'h0, exp_pwr(pwr, en)});
    rdchk(8'h00, 8'h7a, {exp_mode(sleep_mode, exp_pwr(pwr, en), record_active), pll_enabled, 4'h0});
    rdchk(8'h00, 8'h7e, cks);
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Guard against a hung run
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    summarize();
  end

  initial begin
    cks = 8'h00;
    en = 8'hcc;
    pwr = 8'h00;
    void'($urandom(32'h5cc4));
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    status();
    rdchk(8'h00, 8'h78, 8'h00);
    $display("test reset done");
    // Active with nothing on, then global power on
    sleep_mode <= 1'b0;
    settle();
    status();
    wr(8'h00, 8'h78, 8'h40);
    settle();
    status();
    $display("test power done");
    // Back-to-back writes to read-only places, another page, an unmapped offset
    wr(8'h00, 8'h79, 8'h00);
    wr(8'h00, 8'h7a, 8'he0);
    wr(8'h01, 8'h78, 8'h02);
    wr(8'h00, 8'h55, 8'h33);
    settle();
    status();
    rdchk(8'h01, 8'h78, 8'h00);
    rdchk(8'h00, 8'h7d, 8'h00);
    $display("test refused done");
    // Preset then wrap past 8 bits
    wr(8'h00, 8'h7e, 8'hff);
    wr(8'h00, 8'h76, 8'h01);
    settle();
    rdchk(8'h00, 8'h7e, 8'hc0);
    $display("test preset done");
    for (int i = 0; i < 40; i++) begin
      sleep_mode <= ($urandom % 4) == 0;
      record_active <= 1'($urandom);
      pll_enabled <= 1'($urandom);
      wr(8'h00, 8'h76, 8'($urandom));
      wr(8'h00, 8'h78, 8'($urandom));
      settle();
      status();
    end
    $display("test random done");
    summarize();
  end
endmodule

// ### sim/host_model.sv
`timescale 1ns/1ps
// Control-port host: one byte per access, strobes change only at rising edges
module host_model (
  input wire logic ref_clk, // Control clock
  input wire logic [7:0] rd_data_q, // Read data from the block
  output dac_power_status_pkg::ctrl_req_type req // Access toward the block
);
  initial req = '0;
  // Reserved bits go out at their reset value, so only legal bytes reach the block
  function automatic logic [7:0] legal(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
    if (pg == 8'h00 && a == dac_power_status_pkg::POWER_CONFIG_OFFSET) return d & 8'h42;
    if (pg == 8'h00 && a == dac_power_status_pkg::CHANNEL_ENABLE_REG_OFFSET) return {4'hc, d[3:0]};
    return d;
  endfunction
  // Write strobe stays up until the caller issues the next access or idles
  task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d, output logic [7:0] sent);
    sent = legal(pg, a, d);
    req <= '{write: 1'b1, read: 1'b0, page: pg, addr: a, wdata: sent};
    @(posedge ref_clk);
  endtask
  // Release the port for one cycle
  task automatic idle;
    req <= '0;
    @(posedge ref_clk);
  endtask
  // Read data lands at the edge after the read edge and stands, so take it one edge later
  task automatic rd(input logic [7:0] pg, input logic [7:0] a, output logic [7:0] q);
    req <= '{write: 1'b0, read: 1'b1, page: pg, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    idle();
    idle();
    q = rd_data_q;
  endtask
endmodule
